// ---- i2c_seq_pkg.sv ----
package i2c_seq_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STAT_OFS   = 8'h04;
  localparam logic [7:0] BUF_OFS    = 8'h08;
  localparam logic [7:0] RATE_OFS   = 8'h0C;

  // control register fields
  localparam int C_EN      = 0;
  localparam int C_START   = 1;
  localparam int C_RESTART = 2;
  localparam int C_STOP    = 3;
  localparam int C_RECV    = 4;
  localparam int C_ACKSEQ  = 5;
  localparam int C_ACKVAL  = 6;
  localparam int C_IRQEN   = 7;

  // status register fields
  localparam int S_IRQ     = 0;
  localparam int S_WRITE_COLLISION    = 1;
  localparam int S_OVF     = 2;
  localparam int S_COLL    = 3;
  localparam int S_ACK     = 4;
  localparam int S_BF      = 5;
  localparam int S_START   = 6;
  localparam int S_STOP    = 7;
  localparam int S_BUSY    = 8;

  // reset values and counts
  localparam logic [7:0]  RATE_RESET   = 8'h09;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [3:0]  LAST_DATA    = 4'h7;
  localparam logic [3:0]  ACK_SLOT     = 4'h8;
  localparam logic [2:0]  SYNC_IDLE    = 3'h7;

  typedef enum logic [4:0] {
    IDLE, START_B, START_C, RS_A, RS_B, RS_C, RS_D, RS_E,
    TX_LOW, TX_RISE, TX_HIGH, RX_LOW, RX_RISE, RX_HIGH,
    ACK_LOW, ACK_RISE, ACK_HIGH,
    STOP_A, STOP_B, STOP_C, STOP_D, STOP_E, STOP_F
  } seq_state_t;

endpackage

// ---- baud_if.sv ----
`timescale 1ns/1ps
interface baud_if;
  logic       load;
  logic       run;
  logic [7:0] reload;
  logic       tick;

  modport counter (input load, input run, input reload, output tick);
  modport ctrl    (output load, output run, output reload, input tick);
endinterface

// ---- baud_counter.sv ----
`timescale 1ns/1ps
module baud_counter
  import i2c_seq_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  baud_if.counter   bif
);

  logic [7:0] count;

  // rollover only while running and not being reloaded
  assign bif.tick = bif.run & ~bif.load & (count == 8'h00);

  // reload then count down to zero, reloading at each rollover
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      count <= 8'h00;
    else if (bif.load || bif.tick)
      count <= bif.reload;
    else if (bif.run)
      count <= count - 8'h01;
  end

endmodule // baud_counter

// ---- i2c_master_byte_sequencer.sv ----
// Decided for this implementation: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
// Notes on behaviour
// R1: buffer write while active sets write_collision
// R2: software clears write_collision before next transfer
// R3: ack_status is zero on ack, one on nack
// R4: start completion raises serial_irq_flag
// R5: idle buffer write shifts 8 bits, msb first
// R6: ninth clock samples ack, raises serial_irq_flag
// R7: stop or restart request raises flag when done
// R8: receive request ignored unless idle
// R9: receive clocks scl per rollover, shifts sda in
// R10: eighth receive bit ends byte, holds scl low
// R11: buffer_full set on load, cleared on read
// R12: byte completing while buffer_full sets overflow
// R13: ack sequence pulls scl low, drives ack_value
// R14: software picks ack_value before ack sequence
// R15: ack clock: period low, release, period high
// R16: stop: sda low, period, scl up, period, sda up
// R17: stop seen on bus, flag one period later
// R18: reset disables port and abandons transfer
// R19: reset or disable clears start and stop seen
// R20: software starts only when bus is free
// R21: bus stop while busy raises interrupt if enabled
// R22: sda compared with intended level for arbitration
// R23: each period reloads from rate_reload to rollover
// R24: arbitration loss flags collision, releases lines
// R25: lines driven only low or released
module i2c_master_byte_sequencer
  import i2c_seq_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        sda_in,
  input  wire logic        scl_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  output logic             scl_out,
  output logic             scl_oe_n,
  output logic             serial_irq
);

  seq_state_t  state;
  seq_state_t  state_q;
  logic [2:0]  sda_sync;
  logic [2:0]  scl_sync;
  logic        sda;
  logic        scl;
  logic        sda_d;
  logic        scl_d;
  logic        dp_wr;
  logic [7:0]  dp_addr;
  logic        enable;
  logic        ack_value;
  logic        irq_en;
  logic        start_req;
  logic        restart_req;
  logic        stop_req;
  logic        recv_req;
  logic        ackseq_req;
  logic [7:0]  rate_reload;
  logic [7:0]  shared_byte_buffer;
  logic [7:0]  bit_shifter;
  logic [3:0]  bit_idx;
  logic        write_collision;
  logic        receive_overflow;
  logic        collision_flag;
  logic        ack_status;
  logic        buffer_full;
  logic        start_seen;
  logic        stop_seen;
  logic [31:0] stat_word;
  logic [31:0] ctrl_word;

  baud_if bif ();

  baud_counter u_baud (
    .hclk    (hclk),
    .hresetn (hresetn),
    .bif     (bif)
  );

  // bus decode: address phase accepted, data phase writes
  wire       acc       = hsel & htrans[1] & hready;
  wire       buf_rd    = acc & ~hwrite & (haddr[7:0] == BUF_OFS);
  wire       wr_ctrl   = dp_wr & (dp_addr == CTRL_OFS);
  wire       wr_stat   = dp_wr & (dp_addr == STAT_OFS);
  wire       wr_buf    = dp_wr & (dp_addr == BUF_OFS);
  wire       wr_rate   = dp_wr & (dp_addr == RATE_OFS);
  wire       idle_now  = (state == IDLE);
  wire       any_req   = start_req | restart_req | stop_req | recv_req | ackseq_req;
  wire       busy      = ~idle_now | any_req;
  wire       req_ok    = wr_ctrl & idle_now & ~any_req & hwdata[C_EN]; // [R8]
  wire       tick      = bif.tick;
  wire       start_det = scl & scl_d & sda_d & ~sda;
  wire       stop_det  = scl & scl_d & ~sda_d & sda;

  // arbitration: released sda must read high wherever we own it
  wire arb_lost = enable & (                                          // [R22]
      (idle_now & start_req & ~(sda & scl))
    | (state == START_B & ~scl)
    | (state == TX_HIGH & sda_oe_n & ~sda & (bit_idx != ACK_SLOT))
    | (state == ACK_HIGH & ack_value & ~sda)
    | (state == RS_C & scl & ~sda)
    | (state == RS_D & ~scl & sda_oe_n)
    | (state == STOP_D & ~scl));

  // any state change reloads the period counter
  assign bif.reload = rate_reload;                                    // [R23]
  assign bif.load   = (state != state_q);
  assign bif.run    = state inside {START_B, START_C, RS_B, RS_D, RS_E, TX_LOW, TX_HIGH,
                                    RX_LOW, RX_HIGH, ACK_LOW, ACK_HIGH, STOP_B, STOP_D, STOP_F};

  // readback words
  always_comb
  begin
    stat_word          = 32'h0000_0000;
    stat_word[S_IRQ]   = serial_irq;
    stat_word[S_WRITE_COLLISION]  = write_collision;
    stat_word[S_OVF]   = receive_overflow;
    stat_word[S_COLL]  = collision_flag;
    stat_word[S_ACK]   = ack_status;
    stat_word[S_BF]    = buffer_full;
    stat_word[S_START] = start_seen;
    stat_word[S_STOP]  = stop_seen;
    stat_word[S_BUSY]  = busy;
    ctrl_word            = CTRL_RESET;
    ctrl_word[C_EN]      = enable;
    ctrl_word[C_START]   = start_req;
    ctrl_word[C_RESTART] = restart_req;
    ctrl_word[C_STOP]    = stop_req;
    ctrl_word[C_RECV]    = recv_req;
    ctrl_word[C_ACKSEQ]  = ackseq_req;
    ctrl_word[C_ACKVAL]  = ack_value;
    ctrl_word[C_IRQEN]   = irq_en;
  end

  wire [31:0] rd_mux = (haddr[7:0] == CTRL_OFS) ? ctrl_word :
                       (haddr[7:0] == STAT_OFS) ? stat_word :
                       (haddr[7:0] == BUF_OFS)  ? {24'h000000, shared_byte_buffer} :
                       (haddr[7:0] == RATE_OFS) ? {24'h000000, rate_reload} : 32'h0000_0000;

  // zero wait states; unmapped reads return zero with okay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_wr     <= 1'b0;
      dp_addr   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      dp_wr   <= acc & hwrite;
      dp_addr <= haddr[7:0];
      if (acc && !hwrite)
        hrdata <= rd_mux;
    end
  end

  // three-stage pin sync; a level counts once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sda_sync <= SYNC_IDLE;
      scl_sync <= SYNC_IDLE;
      sda      <= 1'b1;
      scl      <= 1'b1;
      sda_d    <= 1'b1;
      scl_d    <= 1'b1;
    end
    else
    begin
      sda_sync <= {sda_sync[1:0], sda_in};
      scl_sync <= {scl_sync[1:0], scl_in};
      if (sda_sync[1] == sda_sync[2])
        sda <= sda_sync[2];
      if (scl_sync[1] == scl_sync[2])
        scl <= scl_sync[2];
      sda_d <= sda;
      scl_d <= scl;
    end
  end

  // bus condition watch; each condition cancels the other
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      start_seen <= 1'b0;                                             // [R19]
      stop_seen  <= 1'b0;
    end
    else if (!enable)
    begin
      start_seen <= 1'b0;                                             // [R19]
      stop_seen  <= 1'b0;
    end
    else if (stop_det)
    begin
      stop_seen  <= 1'b1;                                             // [R17]
      start_seen <= 1'b0;
    end
    else if (start_det)
    begin
      start_seen <= 1'b1;
      stop_seen  <= 1'b0;
    end
  end

  // plain configuration registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      enable      <= 1'b0;
      ack_value   <= 1'b0;
      irq_en      <= 1'b0;
      rate_reload <= RATE_RESET;
      state_q     <= IDLE;
      sda_out     <= 1'b0;                                            // [R25]
      scl_out     <= 1'b0;
    end
    else
    begin
      state_q <= state;
      if (wr_ctrl)
      begin
        enable    <= hwdata[C_EN];
        ack_value <= hwdata[C_ACKVAL];                                // [R14]
        irq_en    <= hwdata[C_IRQEN];
      end
      if (wr_rate)
        rate_reload <= hwdata[7:0];
    end
  end

  // sequencer; sticky flags clear on write-one, later sets win
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= IDLE;                                                  // [R18]
      sda_oe_n <= 1'b1;
      scl_oe_n <= 1'b1;
      bit_idx <= 4'h0;
      start_req <= 1'b0;
      restart_req <= 1'b0;
      stop_req <= 1'b0;
      recv_req <= 1'b0;
      ackseq_req <= 1'b0;
      serial_irq <= 1'b0;
      write_collision <= 1'b0;
      receive_overflow <= 1'b0;
      collision_flag <= 1'b0;
      ack_status <= 1'b0;
      buffer_full <= 1'b0;
      shared_byte_buffer <= 8'h00;
      bit_shifter <= 8'h00;
    end
    else
    begin
      if (wr_stat)
      begin
        if (hwdata[S_IRQ])  serial_irq <= 1'b0;
        if (hwdata[S_WRITE_COLLISION]) write_collision <= 1'b0;                  // [R2]
        if (hwdata[S_OVF])  receive_overflow <= 1'b0;
        if (hwdata[S_COLL]) collision_flag <= 1'b0;
      end
      if (buf_rd)
        buffer_full <= 1'b0;                                          // [R11]
      // only one request at a time, in priority order
      if (req_ok)
      begin
        start_req   <= hwdata[C_START];
        restart_req <= hwdata[C_RESTART] & ~hwdata[C_START];
        stop_req    <= hwdata[C_STOP] & ~|hwdata[C_RESTART:C_START];
        recv_req    <= hwdata[C_RECV] & ~|hwdata[C_STOP:C_START];    // [R8]
        ackseq_req  <= hwdata[C_ACKSEQ] & ~|hwdata[C_RECV:C_START];
      end
      if (wr_buf && (busy || !enable))
        write_collision <= 1'b1;                                      // [R1]
      else if (wr_buf)
      begin
        shared_byte_buffer <= hwdata[7:0];                            // [R5]
        bit_shifter        <= hwdata[7:0];
        buffer_full        <= 1'b1;
        bit_idx            <= 4'h0;
        scl_oe_n           <= 1'b0;
        state              <= TX_LOW;
      end
      if (stop_det && start_seen && irq_en && idle_now && !stop_req)
        serial_irq <= 1'b1;                                           // [R21]
      case (state)
        IDLE:
        begin
          if (start_req && enable)
            state <= START_B;
          else if (restart_req)
          begin
            scl_oe_n <= 1'b0;
            state    <= RS_A;
          end
          else if (stop_req)
          begin
            sda_oe_n <= 1'b0;                                         // [R16]
            scl_oe_n <= 1'b0;
            state    <= STOP_A;
          end
          else if (recv_req)
          begin
            sda_oe_n <= 1'b1;
            bit_idx  <= 4'h0;
            state    <= RX_LOW;
          end
          else if (ackseq_req)
          begin
            scl_oe_n <= 1'b0;                                         // [R13]
            sda_oe_n <= ack_value;
            state    <= ACK_LOW;
          end
        end
        START_B: if (tick) begin sda_oe_n <= 1'b0; state <= START_C; end
        START_C:
          if (tick)
          begin
            start_req  <= 1'b0;
            serial_irq <= 1'b1;                                       // [R4]
            state      <= IDLE;
          end
        RS_A: if (!scl) begin sda_oe_n <= 1'b1; state <= RS_B; end
        RS_B: if (tick) begin scl_oe_n <= 1'b1; state <= RS_C; end
        RS_C: if (scl) state <= RS_D;
        RS_D: if (tick) begin sda_oe_n <= 1'b0; state <= RS_E; end
        RS_E:
          if (tick)
          begin
            scl_oe_n    <= 1'b0;
            restart_req <= 1'b0;
            serial_irq  <= 1'b1;                                      // [R7]
            state       <= IDLE;
          end
        TX_LOW:
        begin
          sda_oe_n <= (bit_idx == ACK_SLOT) | bit_shifter[7];         // [R5] [R25]
          if (tick) begin scl_oe_n <= 1'b1; state <= TX_RISE; end
        end
        TX_RISE:
          if (scl)
          begin
            if (bit_idx == ACK_SLOT)
              ack_status <= sda;                                      // [R3] [R6]
            state <= TX_HIGH;
          end
        TX_HIGH:
          if (tick)
          begin
            scl_oe_n <= 1'b0;
            if (bit_idx == LAST_DATA)
              buffer_full <= 1'b0;
            if (bit_idx == ACK_SLOT)
            begin
              serial_irq <= 1'b1;                                     // [R6]
              state      <= IDLE;
            end
            else
            begin
              bit_shifter <= {bit_shifter[6:0], 1'b0};
              bit_idx     <= bit_idx + 4'h1;
              state       <= TX_LOW;
            end
          end
        RX_LOW: if (tick) begin scl_oe_n <= 1'b1; state <= RX_RISE; end // [R9]
        RX_RISE: if (scl) state <= RX_HIGH;
        RX_HIGH:
          if (tick)
          begin
            scl_oe_n    <= 1'b0;                                      // [R9]
            bit_shifter <= {bit_shifter[6:0], sda};
            bit_idx     <= bit_idx + 4'h1;
            state       <= RX_LOW;
            if (bit_idx == LAST_DATA)
            begin
              recv_req           <= 1'b0;                             // [R10]
              shared_byte_buffer <= {bit_shifter[6:0], sda};
              buffer_full        <= 1'b1;                             // [R11]
              serial_irq         <= 1'b1;
              state              <= IDLE;
              if (buffer_full && !buf_rd)
                receive_overflow <= 1'b1;                             // [R12]
            end
          end
        ACK_LOW: if (tick) begin scl_oe_n <= 1'b1; state <= ACK_RISE; end // [R15]
        ACK_RISE: if (scl) state <= ACK_HIGH;
        ACK_HIGH:
          if (tick)
          begin
            scl_oe_n   <= 1'b0;                                       // [R15]
            ackseq_req <= 1'b0;
            serial_irq <= 1'b1;
            state      <= IDLE;
          end
        STOP_A: if (!sda) state <= STOP_B;
        STOP_B: if (tick) begin scl_oe_n <= 1'b1; state <= STOP_C; end
        STOP_C: if (scl) state <= STOP_D;
        STOP_D: if (tick) begin sda_oe_n <= 1'b1; state <= STOP_E; end // [R16]
        STOP_E: if (sda && scl) state <= STOP_F;
        STOP_F:
          if (tick)
          begin
            stop_req   <= 1'b0;                                       // [R17]
            serial_irq <= 1'b1;                                       // [R7]
            state      <= IDLE;
          end
        default: state <= IDLE;
      endcase
      // lost arbitration or disabled port: drop everything, release lines
      if (arb_lost || !enable)
      begin
        state       <= IDLE;                                          // [R24]
        sda_oe_n    <= 1'b1;
        scl_oe_n    <= 1'b1;
        start_req   <= 1'b0;
        restart_req <= 1'b0;
        stop_req    <= 1'b0;
        recv_req    <= 1'b0;
        ackseq_req  <= 1'b0;
        if (arb_lost)
        begin
          collision_flag <= 1'b1;                                     // [R22]
          buffer_full    <= 1'b0;
        end
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  write_collision_hold_a: assert property (wr_buf && busy |=> write_collision && $stable(shared_byte_buffer)) // [R1]
    else $error("buffer write while busy not refused");
  ack_capture_a: assert property (state == TX_RISE && bit_idx == ACK_SLOT && scl && enable && !arb_lost
    |=> ack_status == $past(sda)) // [R3]
    else $error("ack_status does not follow sampled sda");
  start_done_a: assert property (state == START_C && tick && enable |=> serial_irq && !start_req) // [R4]
    else $error("start completion did not raise flag");
  tx_launch_a: assert property (wr_buf && !busy && enable |=> state == TX_LOW && !scl_oe_n && buffer_full) // [R5]
    else $error("idle buffer write did not start transmit");
  rx_ignore_a: assert property (wr_ctrl && busy && !recv_req |=> !recv_req) // [R8]
    else $error("receive request accepted while busy");
  rx_done_a: assert property (state == RX_HIGH && tick && bit_idx == LAST_DATA && enable
    |=> !recv_req && buffer_full && serial_irq && !scl_oe_n && state == IDLE) // [R10]
    else $error("receive completion effects missing");
  overflow_a: assert property (state == RX_HIGH && tick && bit_idx == LAST_DATA && enable && buffer_full
    && !buf_rd |=> receive_overflow) // [R12]
    else $error("overflow not flagged");
  ack_drive_a: assert property (idle_now && ackseq_req && enable && !start_req && !restart_req && !stop_req
    && !recv_req |=> !scl_oe_n && sda_oe_n == $past(ack_value)) // [R13]
    else $error("ack sequence did not drive lines");
  arb_release_a: assert property (arb_lost |=> state == IDLE && sda_oe_n && scl_oe_n && collision_flag) // [R24]
    else $error("arbitration loss not handled");
  seen_clear_a: assert property (!enable |=> !start_seen && !stop_seen) // [R19]
    else $error("seen bits not cleared while disabled");

  tx_byte_c: cover property (state == TX_HIGH && tick && bit_idx == ACK_SLOT);
  rx_byte_c: cover property (state == RX_HIGH && tick && bit_idx == LAST_DATA);
  stop_done_c: cover property (state == STOP_F && tick);
  arb_loss_c: cover property (arb_lost);

endmodule // i2c_master_byte_sequencer

// ---- i2c_slave_model.sv ----
`timescale 1ns/1ps
module i2c_slave_model
(
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       nack,
  input  wire logic       rd_mode,
  input  wire logic [7:0] tx_byte,
  output logic            pull,
  output logic [7:0]      rx_byte,
  output logic            rx_strobe
);
  int         pos = -1;
  logic [7:0] shifter = 8'h00;

  // strobe starts low; the bench ignores the power-up edge
  initial
    rx_strobe = 1'b0;

  // slot 8 is the ack slot; read bytes are served msb first, released otherwise
  assign pull = (pos == 8) ? (!rd_mode && !nack) : (pos >= 0 && rd_mode && !tx_byte[7 - pos]);

  // a start on the wires restarts the bit count
  always @(negedge sda)
    if (scl === 1'b1)
      pos = -1;

  // data is taken while the clock is high
  always @(posedge scl)
    if (pos < 8)
      shifter = {shifter[6:0], sda};

  // toggling strobe hands each written byte to the bench
  always @(negedge scl)
  begin
    pos = (pos == 8) ? 0 : pos + 1;
    if (pos == 8 && !rd_mode)
    begin
      rx_byte = shifter;
      rx_strobe = ~rx_strobe;
    end
  end
endmodule // i2c_slave_model

// ---- i2c_master_byte_sequencer_tb.sv ----
`timescale 1ns/1ps
module i2c_master_byte_sequencer_tb;
  import i2c_seq_pkg::*;
  typedef struct {string name; logic [31:0] exp; logic [31:0] mask;} note_t;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seen, seed = 32'hAEAA4059;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, sda_out, sda_oe_n, scl_out, scl_oe_n, serial_irq;
  logic        pull, rx_strobe, nack = 1'b0, rd_mode = 1'b0;
  logic [7:0]  rx_byte, tx_byte = 8'h00;
  int          n_errors = 0, total_checks = 0;
  note_t       notes[$];
  logic [7:0]  sent[$];
  event        rd_ev;
  // open-drain wires with pull-ups
  wire         sda = (sda_oe_n && !pull) ? 1'b1 : 1'b0;
  wire         scl = scl_oe_n ? 1'b1 : 1'b0;

  i2c_master_byte_sequencer u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sda_in(sda), .scl_in(scl), .sda_out, .sda_oe_n,
    .scl_out, .scl_oe_n, .serial_irq);
  i2c_slave_model u_slave (.scl, .sda, .nack, .rd_mode, .tx_byte, .pull, .rx_byte, .rx_strobe);

  initial
    forever #2.5 hclk = ~hclk;

  // guard against a hung handshake
  initial
  begin
    repeat (40000) @(posedge hclk);
    n_errors++;
    print_verdict;
  end

  task automatic check(input string name, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", name, e, s);
    end
  endtask

  // results are matched to the oldest outstanding note
  always @(rd_ev)
  begin
    note_t n;
    n = notes.pop_front();
    check(n.name, seen & n.mask, n.exp & n.mask);
  end
  // the time-zero settling of the strobe is not a byte
  always @(rx_strobe)
    if (hresetn === 1'b1)
      check("slave byte", {24'h0, rx_byte}, {24'h0, sent.pop_front()});

  // single word transfer; no fixed latency is assumed
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask

  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    notes.push_back('{name, e, m});
    seen = q;
    ->rd_ev;
  endtask

  // wait for the flag, then clear it by writing one
  task automatic wait_irq;
    for (int i = 0; i < 4000 && serial_irq !== 1'b1; i++) @(posedge hclk);
    check("irq raised", {31'h0, serial_irq}, 32'h1);
    wr(STAT_OFS, 32'h1);
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic send;
    seed = xs(seed);
    sent.push_back(seed[7:0]);
    wr(BUF_OFS, {24'h0, seed[7:0]});
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // main sequence; waits end on the flag, except fixed 100-cycle waits in the arbitration and reset steps
  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rd("ctrl reset", CTRL_OFS, CTRL_RESET, 32'hFFFFFFFF);
    rd("status reset", STAT_OFS, 32'h0, 32'h1FF);
    rd("rate reset", RATE_OFS, {24'h0, RATE_RESET}, 32'hFF);
    rd("unmapped", 8'h10, 32'h0, 32'hFFFFFFFF);
    wr(RATE_OFS, 32'h0F);
    rd("rate write", RATE_OFS, 32'h0F, 32'hFF);
    wr(CTRL_OFS, 32'h1);
    wr(CTRL_OFS, 32'h3);
    wait_irq;
    rd("start seen", STAT_OFS, 32'h40, 32'h40);
    $display("test start done");
    send;
    wr(BUF_OFS, 32'h0);
    wait_irq;
    rd("collision ack", STAT_OFS, 32'h2, 32'h12);
    wr(STAT_OFS, 32'h2);
    rd("collision clear", STAT_OFS, 32'h0, 32'h2);
    check("drive level", {29'h0, hresp, sda_out, scl_out}, 32'h0);
    nack <= 1'b1;
    send;
    wait_irq;
    rd("nack status", STAT_OFS, 32'h10, 32'h10);
    nack <= 1'b0;
    wr(CTRL_OFS, 32'h5);
    wait_irq;
    send;
    wait_irq;
    rd("ack after restart", STAT_OFS, 32'h0, 32'h10);
    $display("test transmit done");
    rd_mode <= 1'b1;
    seed = xs(seed);
    tx_byte <= seed[7:0];
    wr(CTRL_OFS, 32'h11);
    wait_irq;
    rd("buffer full", STAT_OFS, 32'h20, 32'h24);
    wr(CTRL_OFS, 32'h21);
    wait_irq;
    seed = xs(seed);
    tx_byte <= seed[7:0];
    wr(CTRL_OFS, 32'h11);
    wait_irq;
    rd("overflow", STAT_OFS, 32'h24, 32'h24);
    rd("received byte", BUF_OFS, {24'h0, seed[7:0]}, 32'hFF);
    rd("full cleared", STAT_OFS, 32'h0, 32'h20);
    wr(CTRL_OFS, 32'h61);
    wait_irq;
    $display("test receive done");
    rd_mode <= 1'b0;
    wr(CTRL_OFS, 32'h9);
    wait_irq;
    rd("stop seen", STAT_OFS, 32'h80, 32'h80);
    wr(CTRL_OFS, 32'h0);
    rd("seen cleared", STAT_OFS, 32'h0, 32'hC0);
    $display("test stop done");
    wr(CTRL_OFS, 32'h1);
    wr(CTRL_OFS, 32'h83);
    wait_irq;
    // slave pulls sda low against a released one: arbitration is lost
    rd_mode <= 1'b1;
    tx_byte <= 8'h00;
    wr(BUF_OFS, 32'h80);
    repeat (100) @(posedge hclk);
    rd("arbitration", STAT_OFS, 32'h8, 32'h129);
    check("released", {30'h0, sda_oe_n, scl_oe_n}, 32'h3);
    // slave lets go while scl is high: a foreign stop on the bus
    rd_mode <= 1'b0;
    wait_irq;
    $display("test arbitration done");
    wr(CTRL_OFS, 32'h3);
    wait_irq;
    wr(BUF_OFS, 32'hA5);
    repeat (100) @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    #1;
    check("reset lines", {30'h0, sda_oe_n, scl_oe_n}, 32'h3);
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd("ctrl after reset", CTRL_OFS, 32'h0, 32'hFF);
    $display("test reset done");
    print_verdict;
  end
endmodule // i2c_master_byte_sequencer_tb
